// ==== rtl/ebwc_consts.vh ====
`ifndef EBWC_CONSTS_VH
`define EBWC_CONSTS_VH
// register offsets
`define EBWC_OFS_ACCESS_STATE 8'hed
`define EBWC_OFS_WAIT_CTRL 8'hee
`define EBWC_OFS_MODE_STATUS 8'hf1
`define EBWC_OFS_AREA_WAIT_EN 8'hf8
`define EBWC_OFS_SYS_CTRL 8'hf9
// reset values
`define EBWC_RST_WAIT_CTRL 8'hf3
`define EBWC_RST_ACCESS_STATE 8'hff
`define EBWC_RST_AREA_WAIT_EN 8'hff
`define EBWC_RST_SYS_CTRL 8'h00
// mode status upper bits read as fixed pattern
`define EBWC_MODE_STATUS_FIXED 6'h30
// field positions
`define EBWC_WMODE_HI 3
`define EBWC_WMODE_LO 2
`define EBWC_WCNT_HI 1
`define EBWC_WCNT_LO 0
`define EBWC_STBY_BIT 7
// edges after reset release before the synced mode pins are valid
`define EBWC_MODE_CAP_DLY 2'h2
// wait modes
`define EBWC_WM_PROG 2'h0
`define EBWC_WM_NONE 2'h1
`define EBWC_WM_PIN 2'h2
`define EBWC_WM_AUTO 2'h3
`endif

// ==== rtl/ebwc_sync2.v ====
// two-flop synchroniser for pin inputs
module ebwc_sync2 #(
  parameter W = 1
) (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  // first stage feeds only the second
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
    end
    else
    begin
      s1_q <= d_i;
      s2_q <= s1_q;
    end
  end
  assign q_o = s2_q;
endmodule // ebwc_sync2

// ==== rtl/ebwc_top.v ====
// The plain strobed port was decided locally.
`include "ebwc_consts.vh"
module ebwc_top #(
  parameter AREAS = 8
) (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire mode_pin_hi_i,
  input wire mode_pin_lo_i,
  input wire ext_wait_i,
  input wire acc_start_i,
  input wire [2:0] acc_area_i,
  output wire acc_busy_o,
  output wire acc_done_o,
  output wire acc_wait_o,
  input wire sleep_exec_i,
  output reg sleep_enter_o,
  output reg standby_enter_o
);
  reg [3:0] wait_ctrl_q;
  reg [AREAS-1:0] area_wait_en_q;
  reg [AREAS-1:0] access_state_q;
  reg [7:0] sys_ctrl_q;
  reg [1:0] mode_status_q;
  reg mode_cap_q;
  reg [1:0] mode_dly_q;
  reg [7:0] rdata_d;
  localparam [7:0] WAIT_CTRL_RST = `EBWC_RST_WAIT_CTRL;
  wire [1:0] mode_pins_s;
  wire ext_wait_s;
  wire [1:0] wait_mode;
  wire [1:0] wait_count;

  // mode pins and wait pin enter through synchronisers
  ebwc_sync2 #(
    .W(3)
  ) u_sync (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .d_i({mode_pin_hi_i, mode_pin_lo_i, ext_wait_i}),
    .q_o({mode_pins_s, ext_wait_s})
  );

  // decoded fields of the wait control register
  assign wait_mode = wait_ctrl_q[`EBWC_WMODE_HI:`EBWC_WMODE_LO];
  assign wait_count = wait_ctrl_q[`EBWC_WCNT_HI:`EBWC_WCNT_LO];

  // software-written registers
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      wait_ctrl_q <= WAIT_CTRL_RST[3:0]; // only the writable nibble is stored
      area_wait_en_q <= {AREAS{1'b1}};
      access_state_q <= {AREAS{1'b1}};
      sys_ctrl_q <= `EBWC_RST_SYS_CTRL;
    end
    else if (wr_i)
    begin
      case (addr_i)
        `EBWC_OFS_WAIT_CTRL:
          wait_ctrl_q <= wdata_i[3:0];
        `EBWC_OFS_AREA_WAIT_EN:
          area_wait_en_q <= wdata_i[AREAS-1:0];
        `EBWC_OFS_ACCESS_STATE:
          access_state_q <= wdata_i[AREAS-1:0];
        `EBWC_OFS_SYS_CTRL:
          sys_ctrl_q <= wdata_i;
        default:
          sys_ctrl_q <= sys_ctrl_q;
      endcase
    end
  end

  // mode pins are caught once, after the synchroniser has refilled past reset
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      mode_status_q <= 2'h0;
      mode_cap_q <= 1'b0;
      mode_dly_q <= 2'h0;
    end
    else if (!mode_cap_q)
    begin
      mode_dly_q <= mode_dly_q + 2'h1;
      if (mode_dly_q == `EBWC_MODE_CAP_DLY)
      begin
        mode_cap_q <= 1'b1;
        mode_status_q <= mode_pins_s;
      end
    end
  end

  // read mux, data in the cycle after the strobe
  always @*
  begin
    rdata_d = 8'h00;
    case (addr_i)
      `EBWC_OFS_WAIT_CTRL:
        rdata_d = {4'hf, wait_ctrl_q};
      `EBWC_OFS_MODE_STATUS:
        rdata_d = {`EBWC_MODE_STATUS_FIXED, mode_status_q};
      `EBWC_OFS_AREA_WAIT_EN:
        rdata_d = area_wait_en_q;
      `EBWC_OFS_ACCESS_STATE:
        rdata_d = access_state_q;
      `EBWC_OFS_SYS_CTRL:
        rdata_d = sys_ctrl_q;
      default:
        rdata_d = 8'h00;
    endcase
  end

  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
      rdata_o <= 8'h00;
    else if (rd_i)
      rdata_o <= rdata_d;
    else
      rdata_o <= 8'h00;
  end

  // sleep instruction routed to sleep or standby
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      sleep_enter_o <= 1'b0;
      standby_enter_o <= 1'b0;
    end
    else
    begin
      sleep_enter_o <= sleep_exec_i & ~sys_ctrl_q[`EBWC_STBY_BIT];
      standby_enter_o <= sleep_exec_i & sys_ctrl_q[`EBWC_STBY_BIT];
    end
  end

  // access cycle sequencer per selected area
  ebwc_wait_seq u_seq (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .start_i(acc_start_i),
    .three_state_i(access_state_q[acc_area_i]),
    .wait_en_i(area_wait_en_q[acc_area_i]),
    .wait_mode_i(wait_mode),
    .wait_count_i(wait_count),
    .ext_wait_i(ext_wait_s),
    .busy_o(acc_busy_o),
    .done_o(acc_done_o),
    .wait_o(acc_wait_o)
  );
endmodule // ebwc_top

// ==== rtl/ebwc_wait_seq.v ====
`include "ebwc_consts.vh"
// wait sequencer: steps through access states and counts inserted wait states
module ebwc_wait_seq (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire start_i,
  input wire three_state_i,
  input wire wait_en_i,
  input wire [1:0] wait_mode_i,
  input wire [1:0] wait_count_i,
  input wire ext_wait_i,
  output wire busy_o,
  output wire done_o,
  output wire wait_o
);
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_ACC = 4'h2;
  localparam [3:0] ST_WAIT = 4'h4;
  localparam [3:0] ST_LAST = 4'h8;
  reg [3:0] st_q;
  reg [3:0] st_d;
  reg [1:0] cnt_q;
  reg [1:0] cnt_d;
  reg [1:0] mode_q;
  reg [1:0] mode_d;
  reg [1:0] wc_q;
  reg [1:0] wc_d;
  reg en_q;
  reg en_d;
  // next state; three-state cycles use two states before the last one
  always @*
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    mode_d = mode_q;
    wc_d = wc_q;
    en_d = en_q;
    case (st_q)
      ST_IDLE:
      begin
        if (start_i)
        begin
          mode_d = wait_mode_i;
          wc_d = wait_count_i;
          en_d = wait_en_i;
          cnt_d = 2'h0;
          st_d = three_state_i ? ST_ACC : ST_LAST;
        end
      end
      ST_ACC:
      begin
        if (!en_q)
          st_d = ext_wait_i ? ST_WAIT : ST_LAST;
        else if (mode_q == `EBWC_WM_NONE)
          st_d = ST_LAST;
        else if (mode_q == `EBWC_WM_PROG)
          st_d = (wc_q == 2'h0) ? ST_LAST : ST_WAIT;
        else if (mode_q == `EBWC_WM_AUTO)
          st_d = (ext_wait_i || wc_q != 2'h0) ? ST_WAIT : ST_LAST;
        else
          st_d = ext_wait_i ? ST_WAIT : ST_LAST;
      end
      ST_WAIT:
      begin
        cnt_d = (cnt_q == 2'h3) ? cnt_q : cnt_q + 2'h1; // saturate so long pin holds do not wrap
        if (en_q && mode_q == `EBWC_WM_PROG)
        begin
          if (cnt_q + 2'h1 == wc_q)
            st_d = ST_LAST;
        end
        else if (en_q && mode_q == `EBWC_WM_AUTO)
        begin
          if ((cnt_q == 2'h3 || cnt_q + 2'h1 >= wc_q) && !ext_wait_i)
            st_d = ST_LAST;
        end
        else if (!ext_wait_i)
          st_d = ST_LAST;
      end
      ST_LAST:
        st_d = ST_IDLE;
      default:
        st_d = ST_IDLE;
    endcase
  end
  // state registers
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      st_q <= ST_IDLE;
      cnt_q <= 2'h0;
      mode_q <= 2'h0;
      wc_q <= 2'h0;
      en_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      mode_q <= mode_d;
      wc_q <= wc_d;
      en_q <= en_d;
    end
  end
  assign busy_o = (st_q != ST_IDLE);
  assign done_o = (st_q == ST_LAST);
  assign wait_o = (st_q == ST_WAIT);
endmodule // ebwc_wait_seq

// ==== verif/ebwc_assertions.sv ====
module ebwc_assertions (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  input wire acc_start_i,
  input wire acc_busy_o,
  input wire acc_done_o,
  input wire acc_wait_o,
  input wire sleep_exec_i,
  input wire sleep_enter_o,
  input wire standby_enter_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // register side
  a_wait_ctrl_rb: assert property (wr_i && addr_i == 8'hee ##1 !wr_i ##1 rd_i && addr_i == 8'hee
    |=> rdata_o == ($past(wdata_i, 3) | 8'hf0)) else $error("wait control readback wrong");
  a_area_bits_rb: assert property (wr_i && (addr_i == 8'hf8 || addr_i == 8'hed)
    ##1 !wr_i && $stable(addr_i) ##1 rd_i && $stable(addr_i) |=> rdata_o == $past(wdata_i, 3))
    else $error("area bits readback wrong");
  a_mode_ro: assert property (rd_i && addr_i == 8'hf1 |=> rdata_o[7:2] == 6'h30)
    else $error("mode status upper bits wrong");
  // access side
  a_acc_ends: assert property (acc_start_i && !acc_busy_o |-> ##[1:40] acc_done_o)
    else $error("access never finished");
  a_done_clean: assert property (acc_done_o |-> !acc_wait_o ##1 !acc_done_o)
    else $error("done overlaps wait or lasts");
  a_wait_busy: assert property (acc_wait_o |-> acc_busy_o)
    else $error("wait outside access");
  // low power entry
  a_stby_pick: assert property (sleep_exec_i |=> sleep_enter_o != standby_enter_o)
    else $error("no single entry after sleep");
  a_enter_cause: assert property (sleep_enter_o || standby_enter_o |-> $past(sleep_exec_i))
    else $error("entry without sleep");
  c_wait: cover property (acc_wait_o);
  c_stby: cover property (standby_enter_o);
  c_done: cover property (acc_done_o);
endmodule // ebwc_assertions
bind ebwc_top ebwc_assertions u_chk (.*);

// ==== verif/ebwc_ext_dev.sv ====
// external device on the bus: holds its wait line for a commanded time
module ebwc_ext_dev (
  input wire mclk_i,
  input wire arm_i,
  input wire [7:0] hold_i,
  output logic wait_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q = 8'h00;
  // load on arm, count down; wait drops back to idle low when released
  always @(posedge mclk_i)
  begin
    if (arm_i)
      cnt_q <= hold_i;
    else if (cnt_q != 8'h00)
      cnt_q <= cnt_q - 8'h01;
  end
  assign wait_o = (cnt_q != 8'h00);
endmodule // ebwc_ext_dev

// ==== verif/ebwc_top_test.sv ====
module ebwc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, hold = 8'h00, rdata_o;
  logic wr_i = 1'b0, rd_i = 1'b0, acc_start_i = 1'b0, sleep_exec_i = 1'b0, arm = 1'b0;
  logic mode_pin_hi_i = 1'b0, mode_pin_lo_i = 1'b1;
  logic [2:0] acc_area_i = 3'h0;
  logic ext_wait_i, acc_busy_o, acc_done_o, acc_wait_o, sleep_enter_o, standby_enter_o;
  int num_errors = 0, check_count = 0, cyc = 0;
  always #5 mclk_i = ~mclk_i;
  ebwc_top dut (.*);
  ebwc_ext_dev dev (.mclk_i(mclk_i), .arm_i(arm), .hold_i(hold), .wait_o(ext_wait_i));
  task chk(input string nm, input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, exp);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    chk($sformatf("reg %h", a), rdata_o, exp);
  endtask
  // arm the far side, start one access, count wait states until done
  task acc(input logic [2:0] ar, input logic [7:0] h, exp);
    logic [7:0] w;
    logic dn;
    w = 8'h00;
    dn = 1'b0;
    @(posedge mclk_i);
    hold <= h;
    arm <= 1'b1;
    @(posedge mclk_i);
    arm <= 1'b0;
    repeat (3) @(posedge mclk_i);
    acc_start_i <= 1'b1;
    acc_area_i <= ar;
    @(posedge mclk_i);
    acc_start_i <= 1'b0;
    repeat (40)
    begin
      @(negedge mclk_i);
      if (acc_wait_o === 1'b1)
        w++;
      if (acc_done_o === 1'b1)
      begin
        dn = 1'b1;
        break;
      end
    end
    chk("done seen", {7'h00, dn}, 8'h01);
    chk("busy at done", {7'h00, acc_busy_o}, 8'h01);
    chk("wait states", (h == 8'h00) ? w : {7'h00, w != 8'h00}, exp);
    // sequencer back to idle one cycle after the last state
    @(negedge mclk_i);
    chk("idle after done", {7'h00, acc_busy_o}, 8'h00);
  endtask
  task sleep_chk(input logic [7:0] sel);
    wr(8'hf9, sel);
    @(posedge mclk_i);
    sleep_exec_i <= 1'b1;
    @(posedge mclk_i);
    sleep_exec_i <= 1'b0;
    @(negedge mclk_i);
    chk("standby", {7'h00, standby_enter_o}, {7'h00, sel[7]});
    chk("sleep", {7'h00, sleep_enter_o}, {7'h00, ~sel[7]});
  endtask
  task close_out;
    if (num_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      close_out();
    end
  end
  initial
  begin
    repeat (5) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    rd(8'hee, 8'hf3);
    rd(8'hf8, 8'hff);
    rd(8'hed, 8'hff);
    rd(8'hf1, 8'hc1);
    wr(8'hf1, 8'h00);
    rd(8'hf1, 8'hc1);
    rd(8'he0, 8'h00);
    wr(8'hee, 8'h5a);
    rd(8'hee, 8'hfa);
    for (int c = 0; c < 4; c++)
    begin
      wr(8'hee, c[7:0]);
      acc(3'h0, 8'h00, c[7:0]);
    end
    wr(8'hee, 8'h07);
    acc(3'h0, 8'h00, 8'h00);
    wr(8'hee, 8'h0e);
    acc(3'h0, 8'h00, 8'h02);
    wr(8'hee, 8'h08);
    acc(3'h0, 8'h00, 8'h00);
    acc(3'h0, 8'h0c, 8'h01);
    wr(8'hee, 8'h03);
    wr(8'hed, 8'h00);
    acc(3'h0, 8'h00, 8'h00);
    wr(8'hed, 8'hff);
    wr(8'hf8, 8'hfe);
    rd(8'hf8, 8'hfe);
    acc(3'h0, 8'h00, 8'h00);
    acc(3'h0, 8'h0c, 8'h01);
    acc(3'h1, 8'h00, 8'h03);
    rd(8'hf9, 8'h00);
    sleep_chk(8'h00);
    sleep_chk(8'h80);
    close_out();
  end
endmodule // ebwc_top_test
